// file: hw/sdidr_pkg.sv
// types of the sensor drive and identity register bank
package sdidr_pkg;

  typedef enum logic [2:0] {
    SDIDR_ST_IDLE,
    SDIDR_ST_RX,
    SDIDR_ST_ACK,
    SDIDR_ST_TX,
    SDIDR_ST_MACK
  } sdidr_state_t;

  typedef enum logic [1:0] {
    SDIDR_PH_ADDR,
    SDIDR_PH_PTR,
    SDIDR_PH_DATA
  } sdidr_phase_t;

  typedef struct packed {
    logic [4:0] chan1_drive_code;
    logic [4:0] chan2_drive_code;
    logic [4:0] chan3_drive_code;
  } sdidr_codes_t;

  typedef struct packed {
    logic [2:0]   scl_sync;
    logic [2:0]   sda_sync;
    sdidr_state_t state;
    sdidr_phase_t phase;
    logic [3:0]   bit_cnt;
    logic [7:0]   shift;
    logic [7:0]   ptr;
    logic [7:0]   data_hi;
    logic         byte_lsb;
    logic         is_read;
    logic         master_nack;
    logic         sda_drive;
    sdidr_codes_t codes;
    logic [4:0]   active_code;
  } sdidr_st_t;

endpackage

// file: hw/sdidr_regs.svh
// offsets, field positions and reset values of the sensor drive and identity registers
`ifndef SDIDR_REGS_SVH
`define SDIDR_REGS_SVH

`define SDIDR_OFF_CHAN1_DRIVE   8'h1f
`define SDIDR_OFF_CHAN2_DRIVE   8'h20
`define SDIDR_OFF_CHAN3_DRIVE   8'h21
`define SDIDR_OFF_MAKER_ID      8'h7e
`define SDIDR_OFF_PART_ID       8'h7f

`define SDIDR_CODE_MSB          15
`define SDIDR_CODE_LSB          11
`define SDIDR_RSVD_MSB          10
`define SDIDR_RSVD_LSB          0

`define SDIDR_CODE_RESET        5'h00
`define SDIDR_RSVD_VALUE        11'h000
`define SDIDR_PTR_RESET         8'h00

`define SDIDR_BITS_PER_BYTE     4'h8
`define SDIDR_LAST_TX_BIT       4'h7

`endif

// file: hw/sdidr_top.sv
// sensor drive-current and identity registers behind a two-wire serial slave
`timescale 1ns/1ps
`include "sdidr_regs.svh"

module sdidr_top #(
  parameter logic [6:0]  DEV_ADDR  = 7'h2a,
  parameter bit          FOUR_CHAN = 1'b1,
  parameter bit          HIGH_RES  = 1'b1,
  parameter logic [15:0] MAKER_ID  = 16'h1a2b,  // arbitrary value
  parameter logic [15:0] PART_LO   = 16'h0101,  // arbitrary value
  parameter logic [15:0] PART_HI   = 16'h0102   // arbitrary value
) (
  input  wire logic                CLK_SYS,
  input  wire logic                SYS_RST,
  input  wire logic                SCL_IN,
  input  wire logic                SDA_IN,
  output      logic                SDA_OUT,
  output      logic                SDA_DRIVE_N,
  input  wire logic [1:0]          SEQ_CHAN,
  input  wire logic [4:0]          CHAN0_DRIVE_CODE,
  output      sdidr_pkg::sdidr_codes_t DRIVE_CODES,
  output      logic [4:0]          ACTIVE_DRIVE_CODE
);

  // ==========================================================
  // register decode
  function automatic logic [15:0] read_word(input logic [7:0] ptr,
                                            input sdidr_pkg::sdidr_codes_t c);
    read_word = 16'h0000;
    unique case (ptr)
      `SDIDR_OFF_CHAN1_DRIVE: read_word = {c.chan1_drive_code, `SDIDR_RSVD_VALUE};
      `SDIDR_OFF_CHAN2_DRIVE: read_word = FOUR_CHAN ?
                                {c.chan2_drive_code, `SDIDR_RSVD_VALUE} : 16'h0000;
      `SDIDR_OFF_CHAN3_DRIVE: read_word = FOUR_CHAN ?
                                {c.chan3_drive_code, `SDIDR_RSVD_VALUE} : 16'h0000;
      `SDIDR_OFF_MAKER_ID:    read_word = MAKER_ID;
      `SDIDR_OFF_PART_ID:     read_word = HIGH_RES ? PART_HI : PART_LO;
      default:                read_word = 16'h0000;
    endcase
  endfunction

  // ==========================================================
  // state
  sdidr_pkg::sdidr_st_t st_reg;
  sdidr_pkg::sdidr_st_t st_next;
  logic                 scl_rise;
  logic                 scl_fall;
  logic                 bus_start;
  logic                 bus_stop;
  logic                 wr_en;
  logic [15:0]          wr_data;
  logic [15:0]          rd_word;
  logic [7:0]           rd_byte;

  assign scl_rise  = st_reg.scl_sync[1] & ~st_reg.scl_sync[2];
  assign scl_fall  = ~st_reg.scl_sync[1] & st_reg.scl_sync[2];
  assign bus_start = st_reg.scl_sync[1] & st_reg.scl_sync[2] &
                     ~st_reg.sda_sync[1] & st_reg.sda_sync[2];
  assign bus_stop  = st_reg.scl_sync[1] & st_reg.scl_sync[2] &
                     st_reg.sda_sync[1] & ~st_reg.sda_sync[2];

  always_comb begin
    st_next          = st_reg;
    wr_en            = 1'b0;
    wr_data          = {st_reg.data_hi, st_reg.shift};
    rd_word          = read_word(st_reg.ptr, st_reg.codes);
    rd_byte          = st_reg.byte_lsb ? rd_word[7:0] : rd_word[15:8];
    st_next.scl_sync = {st_reg.scl_sync[1:0], SCL_IN};
    st_next.sda_sync = {st_reg.sda_sync[1:0], SDA_IN};
    if (bus_start) begin
      st_next.state     = sdidr_pkg::SDIDR_ST_RX;
      st_next.phase     = sdidr_pkg::SDIDR_PH_ADDR;
      st_next.bit_cnt   = 4'h0;
      st_next.byte_lsb  = 1'b0;
      st_next.sda_drive = 1'b0;
    end else if (bus_stop) begin
      st_next.state     = sdidr_pkg::SDIDR_ST_IDLE;
      st_next.sda_drive = 1'b0;
    end else begin
      unique case (st_reg.state)
        sdidr_pkg::SDIDR_ST_IDLE: begin
          st_next.sda_drive = 1'b0;
        end
        sdidr_pkg::SDIDR_ST_RX: begin
          if (scl_rise) begin
            st_next.shift   = {st_reg.shift[6:0], st_reg.sda_sync[1]};
            st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
          end else if (scl_fall && st_reg.bit_cnt == `SDIDR_BITS_PER_BYTE) begin
            st_next.state     = sdidr_pkg::SDIDR_ST_ACK;
            st_next.sda_drive = 1'b1;
            unique case (st_reg.phase)
              sdidr_pkg::SDIDR_PH_ADDR: begin
                st_next.is_read = st_reg.shift[0];
                if (st_reg.shift[7:1] != DEV_ADDR) begin
                  st_next.state     = sdidr_pkg::SDIDR_ST_IDLE;
                  st_next.sda_drive = 1'b0;
                end
              end
              sdidr_pkg::SDIDR_PH_PTR: begin
                st_next.ptr      = st_reg.shift;
                st_next.byte_lsb = 1'b0;
              end
              default: begin
                if (!st_reg.byte_lsb) begin
                  st_next.data_hi  = st_reg.shift;
                  st_next.byte_lsb = 1'b1;
                end else begin
                  wr_en            = 1'b1;
                  st_next.ptr      = st_reg.ptr + 8'h01;
                  st_next.byte_lsb = 1'b0;
                end
              end
            endcase
          end
        end
        sdidr_pkg::SDIDR_ST_ACK: begin
          if (scl_fall) begin
            st_next.bit_cnt = 4'h0;
            if (st_reg.phase == sdidr_pkg::SDIDR_PH_ADDR && st_reg.is_read) begin
              st_next.state     = sdidr_pkg::SDIDR_ST_TX;
              st_next.shift     = rd_byte;
              st_next.sda_drive = ~rd_byte[7];
            end else begin
              st_next.state     = sdidr_pkg::SDIDR_ST_RX;
              st_next.sda_drive = 1'b0;
              st_next.phase     = (st_reg.phase == sdidr_pkg::SDIDR_PH_ADDR) ?
                                  sdidr_pkg::SDIDR_PH_PTR : sdidr_pkg::SDIDR_PH_DATA;
            end
          end
        end
        sdidr_pkg::SDIDR_ST_TX: begin
          if (scl_fall) begin
            if (st_reg.bit_cnt == `SDIDR_LAST_TX_BIT) begin
              st_next.state     = sdidr_pkg::SDIDR_ST_MACK;
              st_next.sda_drive = 1'b0;
              if (st_reg.byte_lsb) begin
                st_next.ptr = st_reg.ptr + 8'h01;
              end
              st_next.byte_lsb = ~st_reg.byte_lsb;
            end else begin
              st_next.shift     = {st_reg.shift[6:0], 1'b0};
              st_next.bit_cnt   = st_reg.bit_cnt + 4'h1;
              st_next.sda_drive = ~st_reg.shift[6];
            end
          end
        end
        sdidr_pkg::SDIDR_ST_MACK: begin
          if (scl_rise) begin
            st_next.master_nack = st_reg.sda_sync[1];
          end else if (scl_fall) begin
            if (st_reg.master_nack) begin
              st_next.state = sdidr_pkg::SDIDR_ST_IDLE;
            end else begin
              st_next.state     = sdidr_pkg::SDIDR_ST_TX;
              st_next.bit_cnt   = 4'h0;
              st_next.shift     = rd_byte;
              st_next.sda_drive = ~rd_byte[7];
            end
          end
        end
      endcase
    end
    // register writes; reserved bits and identity words are not stored
    if (wr_en) begin
      if (st_reg.ptr == `SDIDR_OFF_CHAN1_DRIVE) begin
        st_next.codes.chan1_drive_code = wr_data[`SDIDR_CODE_MSB:`SDIDR_CODE_LSB];
      end
      if (FOUR_CHAN && st_reg.ptr == `SDIDR_OFF_CHAN2_DRIVE) begin
        st_next.codes.chan2_drive_code = wr_data[`SDIDR_CODE_MSB:`SDIDR_CODE_LSB];
      end
      if (FOUR_CHAN && st_reg.ptr == `SDIDR_OFF_CHAN3_DRIVE) begin
        st_next.codes.chan3_drive_code = wr_data[`SDIDR_CODE_MSB:`SDIDR_CODE_LSB];
      end
    end
    // code applied while the sequenced channel settles and converts
    unique case (SEQ_CHAN)
      2'h0: st_next.active_code = CHAN0_DRIVE_CODE;
      2'h1: st_next.active_code = st_reg.codes.chan1_drive_code;
      2'h2: st_next.active_code = st_reg.codes.chan2_drive_code;
      2'h3: st_next.active_code = st_reg.codes.chan3_drive_code;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      st_reg          <= '0;
      st_reg.scl_sync <= 3'h7;
      st_reg.sda_sync <= 3'h7;
      st_reg.ptr      <= `SDIDR_PTR_RESET;
      st_reg.codes    <= {`SDIDR_CODE_RESET, `SDIDR_CODE_RESET, `SDIDR_CODE_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  assign SDA_OUT           = 1'b0;
  assign SDA_DRIVE_N       = ~st_reg.sda_drive;
  assign DRIVE_CODES       = st_reg.codes;
  assign ACTIVE_DRIVE_CODE = st_reg.active_code;

  // ==========================================================
  // assertions
  property p_ch1_write;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (wr_en && st_reg.ptr == `SDIDR_OFF_CHAN1_DRIVE) |=>
      DRIVE_CODES.chan1_drive_code == $past(wr_data[15:11]);
  endproperty
  a_ch1_write: assert property (p_ch1_write) else $error("channel 1 code not written");

  property p_reset_zero;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    $fell(SYS_RST) |-> (DRIVE_CODES == '0 && ACTIVE_DRIVE_CODE == 5'h00);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("codes not reset");

  property p_apply_code;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (SEQ_CHAN == 2'h1) ##1 (SEQ_CHAN == 2'h1) |->
      ACTIVE_DRIVE_CODE == $past(DRIVE_CODES.chan1_drive_code);
  endproperty
  a_apply_code: assert property (p_apply_code) else $error("channel 1 not applied");

  property p_ch2_write;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (FOUR_CHAN && wr_en && st_reg.ptr == `SDIDR_OFF_CHAN2_DRIVE) |=>
      DRIVE_CODES.chan2_drive_code == $past(wr_data[15:11]);
  endproperty
  a_ch2_write: assert property (p_ch2_write) else $error("channel 2 code not written");

  property p_rsvd_zero;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (st_reg.ptr inside {`SDIDR_OFF_CHAN1_DRIVE, `SDIDR_OFF_CHAN2_DRIVE,
                        `SDIDR_OFF_CHAN3_DRIVE}) |-> rd_word[10:0] == 11'h000;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");

  property p_maker_id;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (st_reg.ptr == `SDIDR_OFF_MAKER_ID) |-> rd_word == MAKER_ID;
  endproperty
  a_maker_id: assert property (p_maker_id) else $error("maker identity wrong");

  property p_part_id;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (st_reg.ptr == `SDIDR_OFF_PART_ID) |-> rd_word == (HIGH_RES ? PART_HI : PART_LO);
  endproperty
  a_part_id: assert property (p_part_id) else $error("part identity wrong");

  property p_two_chan;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (!FOUR_CHAN && st_reg.ptr inside {`SDIDR_OFF_CHAN2_DRIVE, `SDIDR_OFF_CHAN3_DRIVE}) |->
      (rd_word == 16'h0000 && DRIVE_CODES.chan2_drive_code == 5'h00);
  endproperty
  a_two_chan: assert property (p_two_chan) else $error("absent channel not zero");

endmodule

// file: verification/sdidr_host.sv
// two-wire bus host model that reaches the register bank
`timescale 1ns/1ps

module sdidr_host #(
  parameter int HALF = 6
) (
  input  wire logic clk,
  input  wire logic sda_wire,
  output      logic scl,
  output      logic sda
);
  // ==========
  // bus conditions, driven on falling clock edges
  // ==========
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  task automatic start();
    repeat (HALF) @(negedge clk);
    sda = 1'b0;
    repeat (HALF) @(negedge clk);
    scl = 1'b0;
  endtask

  task automatic stop();
    repeat (2) @(negedge clk);
    sda = 1'b0;
    repeat (HALF) @(negedge clk);
    scl = 1'b1;
    repeat (HALF) @(negedge clk);
    sda = 1'b1;
  endtask

  // ==========
  // one byte plus acknowledge, msb first; a released line reads the pull-up
  // ==========
  task automatic xfer(input logic [7:0] tx, input logic ack_tx,
                      output logic [7:0] rx, output logic ack_rx);
    logic [8:0] o;
    logic [8:0] i;
    o = {tx, ack_tx};
    for (int k = 8; k >= 0; k--) begin
      repeat (2) @(negedge clk);
      sda = o[k];
      repeat (HALF) @(negedge clk);
      scl = 1'b1;
      repeat (3) @(negedge clk);
      i[k] = sda_wire;
      repeat (3) @(negedge clk);
      scl = 1'b0;
    end
    rx = i[8:1];
    ack_rx = i[0];
  endtask
endmodule

// file: verification/sdidr_top_tb_top.sv
// self-checking bench of the sensor drive and identity register bank
`timescale 1ns/1ps

module sdidr_top_tb_top;
  localparam logic [15:0] MAKER = 16'h1a2b;  // arbitrary value
  localparam logic [15:0] P_LO  = 16'h0101;  // arbitrary value
  localparam logic [15:0] P_HI  = 16'h0102;  // arbitrary value
  localparam logic [6:0]  A4    = 7'h2a;
  localparam logic [6:0]  A2    = 7'h2b;

  logic                    clk_sys;
  logic                    sys_rst;
  logic [1:0]              seq_chan;
  logic [4:0]              chan0_code;
  logic                    out4;
  logic                    drv_n4;
  logic                    out2;
  logic                    drv_n2;
  logic [4:0]              act4;
  logic [4:0]              act2;
  sdidr_pkg::sdidr_codes_t codes4;
  sdidr_pkg::sdidr_codes_t codes2;
  logic                    scl;
  logic                    sda;
  int                      n_errors;
  int                      comparisons;
  wire                     sda_wire = sda & (drv_n4 | out4) & (drv_n2 | out2);

  sdidr_top #(.DEV_ADDR(A4), .FOUR_CHAN(1'b1), .HIGH_RES(1'b1), .MAKER_ID(MAKER),
              .PART_LO(P_LO), .PART_HI(P_HI)) uut (
    .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .SCL_IN(scl), .SDA_IN(sda_wire),
    .SDA_OUT(out4), .SDA_DRIVE_N(drv_n4), .SEQ_CHAN(seq_chan),
    .CHAN0_DRIVE_CODE(chan0_code), .DRIVE_CODES(codes4), .ACTIVE_DRIVE_CODE(act4));
  sdidr_top #(.DEV_ADDR(A2), .FOUR_CHAN(1'b0), .HIGH_RES(1'b0), .MAKER_ID(MAKER),
              .PART_LO(P_LO), .PART_HI(P_HI)) uut2 (
    .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .SCL_IN(scl), .SDA_IN(sda_wire),
    .SDA_OUT(out2), .SDA_DRIVE_N(drv_n2), .SEQ_CHAN(seq_chan),
    .CHAN0_DRIVE_CODE(chan0_code), .DRIVE_CODES(codes2), .ACTIVE_DRIVE_CODE(act2));
  sdidr_host host (.clk(clk_sys), .sda_wire(sda_wire), .scl(scl), .sda(sda));

  // ==========
  // shared tasks
  // ==========
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic put(input logic [7:0] b, output logic a);
    logic [7:0] r;
    host.xfer(b, 1'b1, r, a);
  endtask

  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [15:0] d);
    logic a;
    logic x;
    host.start();
    put({dev, 1'b0}, a);
    put(ptr, x);
    put(d[15:8], x);
    put(d[7:0], x);
    host.stop();
    check("address ack", {15'h0000, a}, 16'h0000);
  endtask

  task automatic rd(input logic [6:0] dev, input logic [7:0] ptr, input logic [15:0] exp,
                    input string name);
    logic        a;
    logic [15:0] d;
    host.start();
    put({dev, 1'b0}, a);
    put(ptr, a);
    host.stop();
    host.start();
    put({dev, 1'b1}, a);
    host.xfer(8'hff, 1'b0, d[15:8], a);
    host.xfer(8'hff, 1'b1, d[7:0], a);
    host.stop();
    check(name, d, exp);
  endtask

  // ==========
  // scenarios
  // ==========
  task automatic t_reset();
    @(negedge clk_sys);
    sys_rst = 1'b1;
    repeat (6) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    check("codes reset", {1'b0, codes4}, 16'h0000);
    rd(A4, 8'h1f, 16'h0000, "chan1 reset");
    rd(A4, 8'h20, 16'h0000, "chan2 reset");
    rd(A4, 8'h21, 16'h0000, "chan3 reset");
    rd(A4, 8'h7e, MAKER, "maker id");
    rd(A4, 8'h7f, P_HI, "part id high res");
  endtask

  task automatic t_codes();
    logic [4:0] exp_act [4];
    exp_act = '{5'h0c, 5'h1f, 5'h0a, 5'h10};
    wr(A4, 8'h1f, 16'hffff);
    wr(A4, 8'h20, 16'h5555);
    wr(A4, 8'h21, 16'h8000);
    rd(A4, 8'h1f, 16'hf800, "chan1 all ones");
    rd(A4, 8'h20, 16'h5000, "chan2 code");
    rd(A4, 8'h21, 16'h8000, "chan3 code");
    check("codes", {1'b0, codes4}, {1'b0, 5'h1f, 5'h0a, 5'h10});
    for (int c = 0; c < 4; c++) begin
      @(negedge clk_sys);
      seq_chan = 2'(c);
      repeat (2) @(negedge clk_sys);
      check("active code", {11'h000, act4}, {11'h000, exp_act[c]});
    end
  endtask

  task automatic t_burst();
    logic a;
    host.start();
    put({A4, 1'b0}, a);
    put(8'h1f, a);
    put(8'h00, a);
    put(8'h00, a);
    put(8'h08, a);
    put(8'h00, a);
    put(8'hf8, a);
    host.stop();
    rd(A4, 8'h1f, 16'h0000, "chan1 all zeros");
    rd(A4, 8'h20, 16'h0800, "chan2 next word");
    rd(A4, 8'h21, 16'h8000, "chan3 lone byte");
  endtask

  task automatic t_ident();
    wr(A4, 8'h7e, 16'h0000);
    wr(A4, 8'h7f, 16'hffff);
    rd(A4, 8'h7e, MAKER, "maker after write");
    rd(A4, 8'h7f, P_HI, "part after write");
  endtask

  task automatic t_two();
    wr(A2, 8'h20, 16'hf800);
    wr(A2, 8'h21, 16'hf800);
    rd(A2, 8'h20, 16'h0000, "two chan chan2");
    rd(A2, 8'h21, 16'h0000, "two chan chan3");
    rd(A2, 8'h7f, P_LO, "part id low res");
    @(negedge clk_sys);
    seq_chan = 2'd3;
    repeat (2) @(negedge clk_sys);
    check("two chan active", {11'h000, act2}, 16'h0000);
    check("two chan codes", {1'b0, codes2}, 16'h0000);
  endtask

  task automatic summarize();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========
  // clock, sequence and watchdog
  // ==========
  always #5 clk_sys = ~clk_sys;

  initial begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    seq_chan = 2'h0;
    chan0_code = 5'h0c;
    n_errors = 0;
    comparisons = 0;
    t_reset();
    t_codes();
    t_burst();
    t_ident();
    t_two();
    t_reset();
    summarize();
  end

  initial begin
    repeat (80000) @(posedge clk_sys);
    n_errors++;
    summarize();
  end
endmodule
